// ==== inc/pcrc_pkg.sv ====
// Constants, register map and field layout of the programmable CRC generator
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package pcrc_pkg;
    localparam int DW = 16;
    localparam int AW = 3;
    // Register offsets (word index)
    localparam logic [AW-1:0] OFS_CTRL   = 3'h0;
    localparam logic [AW-1:0] OFS_TERMS  = 3'h1;
    localparam logic [AW-1:0] OFS_WDATA  = 3'h2;
    localparam logic [AW-1:0] OFS_RESULT = 3'h3;
    localparam logic [AW-1:0] OFS_ISTAT  = 3'h4;
    localparam logic [AW-1:0] OFS_IMASK  = 3'h5;
    // Control register fields
    localparam int CTRL_PLEN_LSB  = 0;
    localparam int CTRL_GO_BIT    = 4;
    localparam int CTRL_EMPTY_BIT = 6;
    localparam int CTRL_FULL_BIT  = 7;
    localparam int CTRL_VW_LSB    = 8;
    localparam int CTRL_SIDL_BIT  = 13;
    // Interrupt status fields
    localparam int IST_EMPTY_BIT  = 0;
    // FIFO sizing
    localparam logic [4:0] DEPTH_LONG  = 5'h08;
    localparam logic [4:0] DEPTH_SHORT = 5'h10;
    localparam logic [3:0] PLEN_SPLIT  = 4'h7;
    // Reset values
    localparam logic [3:0]    PLEN_RST   = 4'h0;
    localparam logic [DW-1:0] TERMS_RST  = 16'h0000;
    localparam logic [DW-1:0] RESULT_RST = 16'h0000;
endpackage

// ==== verilog/pcrc_top.sv ====
// Programmable CRC generator: register port, word FIFO, serial shifter, interrupt
`timescale 1ns/1ps
`default_nettype none
module pcrc_top
    import pcrc_pkg::*;
(
    input  wire logic          CLK,
    input  wire logic          SRST,
    input  wire logic [AW-1:0] ADDR,
    input  wire logic [DW-1:0] WDATA,
    input  wire logic          WR,
    input  wire logic          RD,
    output logic      [DW-1:0] RDATA,
    input  wire logic          SLEEP,
    input  wire logic          IDLE,
    output logic               IRQ
);

    //--------------------------------------------------------------------------
    // Functions
    //--------------------------------------------------------------------------
    function automatic logic [4:0] fifo_depth(input logic [3:0] plen);
        fifo_depth = (plen > PLEN_SPLIT) ? DEPTH_LONG : DEPTH_SHORT;
    endfunction

    function automatic logic [3:0] ptr_inc(input logic [3:0] ptr, input logic [4:0] depth);
        logic [4:0] lim;
        lim = depth - 5'h01;
        ptr_inc = (ptr + 4'h1) & lim[3:0];
    endfunction

    function automatic logic [DW-1:0] len_mask(input logic [3:0] plen);
        logic [DW:0] m;
        m = ({{DW{1'b0}}, 1'b1} << ({1'b0, plen} + 5'h01)) - {{DW{1'b0}}, 1'b1};
        len_mask = m[DW-1:0];
    endfunction

    //--------------------------------------------------------------------------
    // State
    //--------------------------------------------------------------------------
    logic [3:0]    plen_r;
    logic          go_r;
    logic          sidl_r;
    logic [DW-1:0] terms_r;
    logic [DW-1:0] result_r;
    logic [DW-1:0] fifo_mem [DEPTH_SHORT];
    logic [3:0]    wr_ptr_r;
    logic [3:0]    rd_ptr_r;
    logic [4:0]    cnt_r;
    logic [3:0]    bit_r;
    logic [DW-1:0] ist_r;
    logic [DW-1:0] imask_r;
    logic [DW-1:0] rdata_r;

    logic [4:0]    cnt_nxt;
    logic [DW-1:0] crc_nxt;
    logic [DW-1:0] ist_nxt;
    logic [DW-1:0] ctrl_view;
    logic [DW-1:0] rd_mux;

    //--------------------------------------------------------------------------
    // Decode
    //--------------------------------------------------------------------------
    wire        wr_ctrl   = WR && (ADDR == OFS_CTRL);
    wire        wr_terms  = WR && (ADDR == OFS_TERMS);
    wire        wr_data   = WR && (ADDR == OFS_WDATA);
    wire        wr_result = WR && (ADDR == OFS_RESULT);
    wire        wr_istat  = WR && (ADDR == OFS_ISTAT);
    wire        wr_imask  = WR && (ADDR == OFS_IMASK);

    // Frozen stops the shifter and word pops only; register and data writes still land
    wire        frozen    = SLEEP || (IDLE && sidl_r);
    wire [4:0]  depth     = fifo_depth(plen_r);
    wire        full      = (cnt_r == depth);
    wire        empty     = (cnt_r == 5'h00);
    wire        push      = wr_data;
    wire        wrap      = push && full;
    wire        step      = go_r && !empty && !frozen;
    wire        pop       = step && (bit_r == plen_r) && !wrap;
    wire [3:0]  bit_idx   = plen_r - bit_r;
    wire [DW-1:0] cur_word = fifo_mem[rd_ptr_r];
    wire        din       = cur_word[bit_idx];                  // MSb first
    wire        fb        = result_r[plen_r] ^ din;
    wire [DW-1:0] poly    = {terms_r[DW-1:1], 1'b1};
    wire        irq_evt   = (cnt_r == 5'h01) && (cnt_nxt == 5'h00);

    //--------------------------------------------------------------------------
    // Next-state logic
    //--------------------------------------------------------------------------
    always_comb begin
        // Count: a write into a full FIFO wraps to zero
        if (wrap) begin
            cnt_nxt = 5'h00;
        end else if (push && !pop) begin
            cnt_nxt = cnt_r + 5'h01;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 5'h01;
        end else begin
            cnt_nxt = cnt_r;
        end
    end

    // Shift one bit per clock into the engine; the top term, bit plen_r+1, falls out of the length mask
    assign crc_nxt = ((result_r << 1) ^ (fb ? poly : {DW{1'b0}})) & len_mask(plen_r);

    // Event set wins over a write-one clear
    assign ist_nxt = (ist_r & ~(wr_istat ? WDATA : {DW{1'b0}}))
                   | ({{(DW-1){1'b0}}, irq_evt} << IST_EMPTY_BIT);

    // Control word as software reads it; count and flags are read-only
    always_comb begin
        ctrl_view = {DW{1'b0}};
        ctrl_view[CTRL_PLEN_LSB +: 4] = plen_r;
        ctrl_view[CTRL_GO_BIT]        = go_r;
        ctrl_view[CTRL_EMPTY_BIT]     = empty;
        ctrl_view[CTRL_FULL_BIT]      = full;
        ctrl_view[CTRL_VW_LSB +: 5]   = cnt_r;
        ctrl_view[CTRL_SIDL_BIT]      = sidl_r;
    end

    // Data and result offsets both read the running CRC
    always_comb begin
        if (ADDR == OFS_CTRL) begin
            rd_mux = ctrl_view;
        end else if (ADDR == OFS_TERMS) begin
            rd_mux = terms_r;
        end else if ((ADDR == OFS_WDATA) || (ADDR == OFS_RESULT)) begin
            rd_mux = result_r;
        end else if (ADDR == OFS_ISTAT) begin
            rd_mux = ist_r;
        end else if (ADDR == OFS_IMASK) begin
            rd_mux = imask_r;
        end else begin
            rd_mux = {DW{1'b0}};
        end
    end

    //--------------------------------------------------------------------------
    // Registers
    //--------------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (SRST) begin
            plen_r  <= PLEN_RST;
            go_r    <= 1'b0;
            sidl_r  <= 1'b0;
            terms_r <= TERMS_RST;
            imask_r <= {DW{1'b0}};
        end else begin
            if (wr_ctrl) begin
                plen_r <= WDATA[CTRL_PLEN_LSB +: 4];
                go_r   <= WDATA[CTRL_GO_BIT];
                sidl_r <= WDATA[CTRL_SIDL_BIT];
            end
            if (wr_terms) begin
                terms_r <= {WDATA[DW-1:1], 1'b0};
            end
            if (wr_imask) begin
                imask_r <= WDATA;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            cnt_r    <= 5'h00;
            wr_ptr_r <= 4'h0;
            rd_ptr_r <= 4'h0;
            bit_r    <= 4'h0;
        end else begin
            cnt_r <= cnt_nxt;
            if (wrap) begin
                wr_ptr_r <= 4'h0;
                rd_ptr_r <= 4'h0;
                bit_r    <= 4'h0;
            end else begin
                if (push) begin
                    wr_ptr_r <= ptr_inc(wr_ptr_r, depth);
                end
                if (pop) begin
                    rd_ptr_r <= ptr_inc(rd_ptr_r, depth);
                    bit_r    <= 4'h0;
                end else if (step) begin
                    bit_r <= bit_r + 4'h1;
                end
            end
        end
    end

    // A word written while full is dropped, not stored
    always_ff @(posedge CLK) begin
        if (push && !wrap) begin
            fifo_mem[wr_ptr_r] <= WDATA;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            result_r <= RESULT_RST;
            ist_r    <= {DW{1'b0}};
            rdata_r  <= {DW{1'b0}};
        end else begin
            if (wr_result) begin
                result_r <= WDATA & len_mask(plen_r);
            end else if (step) begin
                result_r <= crc_nxt;
            end
            ist_r <= ist_nxt;
            if (RD) begin
                rdata_r <= rd_mux;
            end
        end
    end

    assign RDATA = rdata_r;
    assign IRQ   = |(ist_r & imask_r);

    //--------------------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    depth_select_a: assert property (full |->
        cnt_r == ((plen_r > 4'h7) ? 5'h08 : 5'h10))
        else $error("full flag at wrong depth");

    full_flag_a: assert property (cnt_r == depth |->
        ctrl_view[CTRL_FULL_BIT] && !ctrl_view[CTRL_EMPTY_BIT])
        else $error("full flag not shown at depth");

    empty_flag_a: assert property (empty |->
        ctrl_view[CTRL_EMPTY_BIT] && !ctrl_view[CTRL_FULL_BIT] && !step)
        else $error("empty flag wrong or shifter running dry");

    push_count_a: assert property (push && !wrap && !pop |=> cnt_r == $past(cnt_r) + 5'h01)
        else $error("count did not rise on write");

    push_store_a: assert property (push && !wrap |=>
        fifo_mem[$past(wr_ptr_r)] == $past(WDATA))
        else $error("written word not stored");

    pop_count_a: assert property (pop && !push |=> cnt_r == $past(cnt_r) - 5'h01)
        else $error("count did not fall on word done");

    bit_time_a: assert property (step && !wrap && (bit_r != plen_r) |=>
        bit_r == $past(bit_r) + 4'h1)
        else $error("shifter skipped a bit");

    pop_restart_a: assert property (pop |=> bit_r == 4'h0)
        else $error("next word did not start at its top bit");

    wrap_empty_a: assert property (wrap |=> cnt_r == 5'h00
        && (!ist_r[IST_EMPTY_BIT] || $past(ist_r[IST_EMPTY_BIT])))
        else $error("write on full did not wrap quietly");

    wrap_ptr_a: assert property (wrap |=>
        wr_ptr_r == 4'h0 && rd_ptr_r == 4'h0 && bit_r == 4'h0)
        else $error("write on full left the FIFO pointers");

    irq_cause_a: assert property ($rose(ist_r[IST_EMPTY_BIT]) |->
        $past(cnt_r) == 5'h01 && cnt_r == 5'h00)
        else $error("interrupt without one to zero");

    irq_raise_a: assert property (cnt_r == 5'h01 && pop && !push |=>
        ist_r[IST_EMPTY_BIT] ##0 empty)
        else $error("one to zero missed its interrupt");

    irq_quiet_a: assert property (!irq_evt && !wr_istat |=> $stable(ist_r))
        else $error("status changed with no event or clear");

    evt_latch_a: assert property (irq_evt |=> ist_r[IST_EMPTY_BIT])
        else $error("one to zero event lost");

    freeze_hold_a: assert property (frozen && !push |=>
        $stable(cnt_r) && $stable(bit_r) && $stable(rd_ptr_r))
        else $error("shifter moved while frozen");

    freeze_result_a: assert property (frozen && !wr_result |=>
        $stable(result_r))
        else $error("result moved while frozen");

    stop_no_go_a: assert property (!go_r && !push && !wr_result |=>
        $stable(cnt_r) && $stable(result_r))
        else $error("shifter ran without shift_go");

    feedback_lsb_a: assert property (step && !wr_result |=> result_r[0] == $past(fb))
        else $error("x0 term not applied");

    reset_state_a: assert property ($past(SRST) |-> cnt_r == 5'h00 && !go_r && empty)
        else $error("reset left block busy");

    // Shift cycles spent on the word that is now leaving the FIFO
    logic [4:0] run_len_r;

    always_ff @(posedge CLK) begin
        if (SRST || pop || wrap) begin
            run_len_r <= 5'h00;
        end else if (step) begin
            run_len_r <= run_len_r + 5'h01;
        end
    end

    word_time_a: assert property (pop |-> run_len_r == {1'b0, plen_r})
        else $error("word did not take its length in shifts");

endmodule
`default_nettype wire

// ==== dv/pcrc_top_tb.sv ====
// Self-checking testbench for the programmable CRC generator
`timescale 1ns/1ps
`default_nettype none
module pcrc_top_tb
    import pcrc_pkg::*;
;
    //--------------------------------------------------------------------------
    // Signals and bookkeeping
    //--------------------------------------------------------------------------
    logic          CLK;
    logic          SRST;
    logic [AW-1:0] ADDR;
    logic [DW-1:0] WDATA;
    logic          WR;
    logic          RD;
    logic [DW-1:0] RDATA;
    logic          SLEEP;
    logic          IDLE;
    logic          IRQ;
    logic [DW-1:0] exp_q[$];
    logic          rd_seen;
    logic [DW-1:0] crc;
    logic [DW-1:0] w;
    int            fail_count;
    int            comparisons;
    int            cycles;
    int            seed;
    int            k;

    pcrc_top pcrc_top_inst (.CLK(CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .SLEEP(SLEEP), .IDLE(IDLE), .IRQ(IRQ));

    initial begin
        CLK = 1'b0; SRST = 1'b1; ADDR = 3'h0; WDATA = 16'h0000; WR = 1'b0; RD = 1'b0;
        SLEEP = 1'b0; IDLE = 1'b0; rd_seen = 1'b0; fail_count = 0; comparisons = 0;
        cycles = 0; seed = 32'h891c;
    end
    always #10 CLK = ~CLK;

    //--------------------------------------------------------------------------
    // Bus tasks, models and compares
    //--------------------------------------------------------------------------
    function automatic logic [DW-1:0] ctrl_v(int plen, int go, int emp, int ful, int cnt, int sidl);
        return DW'(plen + (go << CTRL_GO_BIT) + (emp << CTRL_EMPTY_BIT) + (ful << CTRL_FULL_BIT)
            + (cnt << CTRL_VW_LSB) + (sidl << CTRL_SIDL_BIT));
    endfunction

    // Serial CRC update, MSb of the word first, one bit per shift
    function automatic logic [DW-1:0] crc_model(logic [DW-1:0] r, logic [DW-1:0] d,
                                                logic [DW-1:0] t, int plen);
        logic fb;
        for (int i = plen; i >= 0; i--) begin
            fb = r[plen] ^ d[i];
            r = ((r << 1) ^ (fb ? {t[15:1], 1'b1} : 16'h0000)) & DW'((1 << (plen + 1)) - 1);
        end
        return r;
    endfunction

    task automatic wr(logic [AW-1:0] a, logic [DW-1:0] d);
        @(posedge CLK);
        ADDR <= a; WDATA <= d; WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask

    task automatic rd(logic [AW-1:0] a, logic [DW-1:0] e);
        @(posedge CLK);
        exp_q.push_back(e);
        ADDR <= a; RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
    endtask

    task automatic chk_irq(logic e);
        @(negedge CLK);
        comparisons++;
        if (IRQ !== e) begin
            fail_count++;
            $display("MISMATCH %0t interrupt %b expected %b", $time, IRQ, e);
        end
    endtask

    // Read data stand in the cycle after the strobe
    always @(posedge CLK) begin
        if (rd_seen) begin
            comparisons++;
            if (exp_q.size() == 0 || RDATA !== exp_q[0]) begin
                fail_count++;
                $display("MISMATCH %0t read data %h", $time, RDATA);
            end
            if (exp_q.size() != 0) void'(exp_q.pop_front());
        end
        rd_seen <= RD;
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    //--------------------------------------------------------------------------
    // Main sequence
    //--------------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge CLK);
        SRST <= 1'b0;
        rd(OFS_CTRL, ctrl_v(0, 0, 1, 0, 0, 0));
        rd(OFS_TERMS, 16'h0000);
        rd(3'h6, 16'h0000);
        chk_irq(1'b0);
        wr(OFS_TERMS, 16'hffff);
        rd(OFS_TERMS, 16'hfffe);
        $display("test reset and terms done");
        for (k = 0; k < 2; k++) begin
            wr(OFS_CTRL, ctrl_v(k ? 8 : 7, 0, 0, 0, 0, 0));
            repeat (k ? 8 : 16) wr(OFS_WDATA, DW'($random(seed)));
            rd(OFS_CTRL, ctrl_v(k ? 8 : 7, 0, 0, 1, k ? 8 : 16, 0));
            wr(OFS_WDATA, 16'h00a5);
            rd(OFS_CTRL, ctrl_v(k ? 8 : 7, 0, 1, 0, 0, 0));
            rd(OFS_ISTAT, 16'h0000);
        end
        $display("test fifo depth done");
        wr(OFS_CTRL, ctrl_v(15, 0, 1, 0, 0, 0));
        wr(OFS_TERMS, 16'h1020);
        wr(OFS_RESULT, 16'h0000);
        wr(OFS_IMASK, 16'h0001);
        w = DW'($random(seed));
        crc = crc_model(16'h0000, w, 16'h1020, 15);
        SLEEP <= 1'b1;
        wr(OFS_WDATA, w);
        wr(OFS_CTRL, ctrl_v(15, 1, 0, 0, 0, 0));
        repeat (30) @(posedge CLK);
        rd(OFS_CTRL, ctrl_v(15, 1, 0, 0, 1, 0));
        SLEEP <= 1'b0;
        repeat (10) @(posedge CLK);
        rd(OFS_CTRL, ctrl_v(15, 1, 0, 0, 1, 0));
        repeat (10) @(posedge CLK);
        rd(OFS_CTRL, ctrl_v(15, 1, 1, 0, 0, 0));
        rd(OFS_WDATA, crc);
        rd(OFS_ISTAT, 16'h0001);
        chk_irq(1'b1);
        wr(OFS_IMASK, 16'h0000);
        chk_irq(1'b0);
        wr(OFS_ISTAT, 16'h0001);
        wr(OFS_IMASK, 16'h0001);
        chk_irq(1'b0);
        $display("test crc and interrupt done");
        w = DW'($random(seed));
        crc = crc_model(crc, w, 16'h1020, 15);
        wr(OFS_CTRL, ctrl_v(15, 1, 0, 0, 0, 1));
        IDLE <= 1'b1;
        wr(OFS_WDATA, w);
        repeat (30) @(posedge CLK);
        rd(OFS_CTRL, ctrl_v(15, 1, 0, 0, 1, 1));
        wr(OFS_CTRL, ctrl_v(15, 1, 0, 0, 0, 0));
        repeat (25) @(posedge CLK);
        rd(OFS_CTRL, ctrl_v(15, 1, 1, 0, 0, 0));
        rd(OFS_WDATA, crc);
        chk_irq(1'b1);
        IDLE <= 1'b0;
        $display("test idle done");
        wr(OFS_CTRL, ctrl_v(4, 0, 0, 0, 0, 0));
        wr(OFS_TERMS, 16'h000a);
        wr(OFS_RESULT, 16'hffff);
        wr(OFS_ISTAT, 16'h0001);
        rd(OFS_RESULT, 16'h001f);
        rd(OFS_ISTAT, 16'h0000);
        crc = 16'h001f;
        repeat (3) begin
            w = DW'($random(seed));
            crc = crc_model(crc, w, 16'h000a, 4);
            wr(OFS_WDATA, w);
        end
        wr(OFS_CTRL, ctrl_v(4, 1, 0, 0, 0, 0));
        w = DW'($random(seed));
        crc = crc_model(crc, w, 16'h000a, 4);
        wr(OFS_WDATA, w);
        rd(OFS_CTRL, ctrl_v(4, 1, 0, 0, 4, 0));
        repeat (25) @(posedge CLK);
        rd(OFS_CTRL, ctrl_v(4, 1, 1, 0, 0, 0));
        rd(OFS_RESULT, crc);
        chk_irq(1'b1);
        $display("test flush done");
        repeat (3) @(posedge CLK);
        print_verdict();
    end
endmodule
`default_nettype wire
